// ===== spsmg_drive_model.sv
// motor drive and encoder model; can stall to build following lag
`timescale 1ns/1ps
`default_nettype none
module spsmg_drive_model import spsmg_pkg::*; (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire spsmg_move_t move_cmd,
  input wire logic drive_enable,
  input wire logic stall,
  input wire logic estop,
  output logic [31:0] enc_pos,
  output logic [31:0] inst_target,
  output logic move_done
);
  logic [2:0] cnt_ff;
  // target jumps at once, encoder follows late: worst case lag
  always_ff @(posedge clk_sys) begin
    move_done <= 1'h0;
    if (!resetn) begin
      enc_pos <= POS_RST;
      inst_target <= POS_RST;
      cnt_ff <= 3'h0;
    end else if (estop) begin
      // a stopped move still reports its end
      move_done <= cnt_ff != 3'h0;
      inst_target <= enc_pos;
      cnt_ff <= 3'h0;
    end else if (move_cmd.start) begin
      inst_target <= move_cmd.target;
      cnt_ff <= 3'h4;
    end else if (cnt_ff != 3'h0 && drive_enable && !stall) begin
      cnt_ff <= cnt_ff - 3'h1;
      if (cnt_ff == 3'h1) begin
        enc_pos <= inst_target;
        move_done <= 1'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== spsmg_guard.sv
// following-error shutdown and software limit checks
`timescale 1ns/1ps
`default_nettype none
module spsmg_guard (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [spsmg_pkg::POS_W-1:0] enc_pos,
  input wire logic [spsmg_pkg::POS_W-1:0] inst_target,
  input wire logic [spsmg_pkg::POS_W-1:0] ferr_limit,
  input wire spsmg_pkg::spsmg_limits_t limits,
  input wire logic moving,
  input wire logic dir_fwd,
  input wire logic fault_clr,
  output logic ferr_trip,
  output logic ferr_fault,
  output logic limit_stop
);
  import spsmg_pkg::*;
  logic signed [POS_W:0] lag;
  logic [POS_W-1:0] lag_abs;
  assign lag = $signed({inst_target[POS_W-1], inst_target}) - $signed({enc_pos[POS_W-1], enc_pos});
  assign lag_abs = lag[POS_W] ? POS_W'(-lag) : lag[POS_W-1:0];

  assign ferr_trip = moving && ferr_limit != POS_RST && lag_abs >= ferr_limit;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ferr_fault <= 1'b0;
    end else if (ferr_trip) begin
      ferr_fault <= 1'b1;
    end else if (fault_clr) begin
      ferr_fault <= 1'b0;
    end
  end

  always_comb begin
    limit_stop = 1'b0;
    if (moving && dir_fwd && limits.fwd_en &&
        $signed(enc_pos) >= $signed(limits.fwd_val)) begin
      limit_stop = 1'b1;
    end
    if (moving && !dir_fwd && limits.rev_en &&
        $signed(enc_pos) <= $signed(limits.rev_val)) begin
      limit_stop = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== spsmg_pkg.sv
// shared constants and types for the stage position store and motion guard
package spsmg_pkg;
  localparam int POS_W = 32;
  localparam int IDX_W = 7;
  localparam int NUM_LOC = 100;
  localparam logic [IDX_W-1:0] LAST_LOC = 7'h63;
  localparam logic [6:0] NODE_MAX = 7'h63;
  localparam logic [6:0] NODE_BCAST = 7'h00;
  localparam logic [4:0] HOT_SHIFT_OFS = 5'h0a;
  localparam logic [POS_W-1:0] POS_RST = 32'h0000_0000;
  localparam logic [IDX_W-1:0] IDX_RST = 7'h00;

  typedef enum logic [1:0] {
    SPSMG_ACC_NONE,
    SPSMG_ACC_BASE,
    SPSMG_ACC_STEP
  } spsmg_acc_sel_t;

  typedef struct packed {
    logic [POS_W-1:0] target;
    logic [POS_W-1:0] velocity;
    logic [POS_W-1:0] accel;
    logic start;
  } spsmg_move_t;

  typedef struct packed {
    logic fwd_en;
    logic rev_en;
    logic [POS_W-1:0] fwd_val;
    logic [POS_W-1:0] rev_val;
  } spsmg_limits_t;
endpackage

// ===== spsmg_pos_bank.sv
// one bank of position memory with execute flags and insert-before shifting
`timescale 1ns/1ps
`default_nettype none
module spsmg_pos_bank (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic ins_en,
  input wire logic [spsmg_pkg::IDX_W-1:0] wr_idx,
  input wire logic [spsmg_pkg::POS_W-1:0] wr_pos,
  input wire logic [spsmg_pkg::IDX_W-1:0] rd_idx,
  output logic [spsmg_pkg::POS_W-1:0] rd_pos,
  output logic rd_used,
  output logic rd_exec
);
  import spsmg_pkg::*;
  logic [POS_W-1:0] pos_ff [NUM_LOC];
  logic [NUM_LOC-1:0] used_ff;
  logic [NUM_LOC-1:0] exec_ff;

  genvar g;
  generate
    for (g = 0; g < NUM_LOC; g++) begin : g_loc
      localparam logic [IDX_W-1:0] GI = IDX_W'(g);
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          used_ff[g] <= 1'b0;
          exec_ff[g] <= 1'b0;
          pos_ff[g] <= POS_RST;
        end else if (wr_en && GI == wr_idx) begin
          pos_ff[g] <= wr_pos;
          used_ff[g] <= 1'b1;
          exec_ff[g] <= 1'b1;
        end else if (wr_en && ins_en && GI > wr_idx) begin
          // shift up one; top entry drops off
          if (g > 0) begin
            pos_ff[g] <= pos_ff[(g > 0) ? g-1 : 0];
            used_ff[g] <= used_ff[(g > 0) ? g-1 : 0];
            exec_ff[g] <= exec_ff[(g > 0) ? g-1 : 0];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rd_pos <= POS_RST;
      rd_used <= 1'b0;
      rd_exec <= 1'b0;
    end else if (rd_idx <= LAST_LOC) begin
      rd_pos <= pos_ff[rd_idx];
      rd_used <= used_ff[rd_idx];
      rd_exec <= exec_ff[rd_idx];
    end else begin
      rd_pos <= POS_RST;
      rd_used <= 1'b0;
      rd_exec <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== spsmg_top.sv
// keypad-driven position store, recall, move issue and motion guarding
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - hold-after-jog keeps the loop closed at the jog end point
// - release-after-jog drops motor drive once a jog ends
// - cancel frees a held motor and stops any move
// - shift 2 latches reference; shift 3 held shows position minus reference
// - reference stays until a new capture replaces it
// - node id 1 to 99 (node_cfg 0 to 99 is taken); accept own node or broadcast zero
// - indexed store writes entered location, offers overwrite or insert if used
// - insert shifts that location and all above up by one
// - sequential store increments index then writes; no insertion
// - separate memory bank per store mode
// - lag against instantaneous target at limit shuts off drive
// - following-error shutdown keeps sequence index unchanged
// - backlash kept in units, applied to all moves including jogs
// - base acceleration for immediate moves and shift speed changes
// - separate jog-step acceleration for stepped jogs
// - immediate moves run at base velocity
// - absolute takes target, relative adds increment; both start on go
// - every store sets execute flag on
// - sequential index loads from last recalled location
// - recall shows location, up/down step, go moves there
// - one-touch digit moves to that index, shift adds 10
// - limits captured from position; enabled with value or turned off
module spsmg_top (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [spsmg_pkg::POS_W-1:0] enc_pos,
  input wire logic [spsmg_pkg::POS_W-1:0] inst_target,
  input wire logic jog_active,
  input wire logic jog_step_mode,
  input wire logic jog_dir_fwd,
  input wire logic jog_shift_change,
  input wire logic hold_after_jog,
  input wire logic seq_store_mode,
  input wire logic one_touch_mode,
  input wire logic key_cancel,
  input wire logic key_shift,
  input wire logic key_shift2,
  input wire logic key_shift3_held,
  input wire logic key_store,
  input wire logic [spsmg_pkg::IDX_W-1:0] store_idx,
  input wire logic store_insert,
  input wire logic key_recall,
  input wire logic [spsmg_pkg::IDX_W-1:0] recall_idx,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic key_digit,
  input wire logic [3:0] digit_val,
  input wire logic key_abs,
  input wire logic key_rel,
  input wire logic [spsmg_pkg::POS_W-1:0] entry_val,
  input wire logic key_go,
  input wire logic seq_move,
  input wire logic move_done,
  input wire logic [6:0] node_cfg,
  input wire logic [6:0] cmd_node,
  input wire logic [spsmg_pkg::POS_W-1:0] base_vel,
  input wire logic [spsmg_pkg::POS_W-1:0] base_acc,
  input wire logic [spsmg_pkg::POS_W-1:0] step_acc,
  input wire logic [spsmg_pkg::POS_W-1:0] backlash,
  input wire logic [spsmg_pkg::POS_W-1:0] ferr_limit,
  input wire logic set_fwd_lim,
  input wire logic set_rev_lim,
  input wire logic fwd_lim_on,
  input wire logic rev_lim_on,
  input wire logic lim_edit_fwd,
  input wire logic lim_edit_rev,
  output logic drive_enable,
  output logic loop_closed,
  output logic estop,
  output spsmg_pkg::spsmg_move_t move_cmd,
  output spsmg_pkg::spsmg_acc_sel_t acc_sel,
  output logic [spsmg_pkg::POS_W-1:0] jog_acc,
  output logic [spsmg_pkg::POS_W-1:0] backlash_out,
  output logic [spsmg_pkg::POS_W-1:0] disp_pos,
  output logic disp_diff,
  output logic store_occupied,
  output logic [spsmg_pkg::IDX_W-1:0] cur_idx,
  output logic [6:0] node_id,
  output logic node_match,
  output spsmg_pkg::spsmg_limits_t limits,
  output logic ferr_fault
);
  import spsmg_pkg::*;

  logic [POS_W-1:0] ref_ff;
  logic [IDX_W-1:0] cur_idx_ff;
  logic [IDX_W-1:0] rd_idx;
  logic [POS_W-1:0] rd_pos_ix, rd_pos_sq;
  logic used_ix, used_sq, exec_ix, exec_sq;
  logic [POS_W-1:0] rd_pos;
  logic wr_ix, wr_sq;
  logic [IDX_W-1:0] wr_idx;
  logic [IDX_W-1:0] nxt_seq_idx;
  logic moving_ff, jog_ff, free_ff, go_rcl_ff, seq_ff;
  logic ferr_trip, limit_stop;
  logic dir_fwd_ff;
  logic [IDX_W-1:0] hot_idx;
  logic fault_clr;
  logic stop_now;
  logic rcl_view_ff;

  assign nxt_seq_idx = (cur_idx_ff >= LAST_LOC) ? LAST_LOC : cur_idx_ff + 7'h01;
  assign hot_idx = IDX_W'({1'b0, digit_val}) + (key_shift ? IDX_W'(HOT_SHIFT_OFS) : IDX_W'(0));

  assign wr_idx = seq_store_mode ? nxt_seq_idx : store_idx;
  assign wr_ix = key_store && !seq_store_mode;
  assign wr_sq = key_store && seq_store_mode;
  // idle reads follow store_idx so occupancy is ready before the store key
  assign rd_idx = (key_digit && one_touch_mode) ? hot_idx :
                  (seq_store_mode || rcl_view_ff || key_go) ? cur_idx_ff : store_idx;
  assign rd_pos = seq_store_mode ? rd_pos_sq : rd_pos_ix;
  assign store_occupied = seq_store_mode ? 1'b0 : used_ix;

  spsmg_pos_bank u_bank_ix (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .wr_en(wr_ix),
    .ins_en(store_insert && used_ix),
    .wr_idx(wr_idx),
    .wr_pos(enc_pos),
    .rd_idx(rd_idx),
    .rd_pos(rd_pos_ix),
    .rd_used(used_ix),
    .rd_exec(exec_ix)
  );

  spsmg_pos_bank u_bank_sq (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .wr_en(wr_sq),
    .ins_en(1'b0),
    .wr_idx(wr_idx),
    .wr_pos(enc_pos),
    .rd_idx(rd_idx),
    .rd_pos(rd_pos_sq),
    .rd_used(used_sq),
    .rd_exec(exec_sq)
  );

  spsmg_guard u_guard (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .enc_pos(enc_pos),
    .inst_target(inst_target),
    .ferr_limit(ferr_limit),
    .limits(limits),
    .moving(moving_ff || jog_active),
    .dir_fwd(jog_active ? jog_dir_fwd : dir_fwd_ff),
    .fault_clr(fault_clr),
    .ferr_trip(ferr_trip),
    .ferr_fault(ferr_fault),
    .limit_stop(limit_stop)
  );

  assign fault_clr = key_cancel || key_abs || key_rel || key_go || (key_digit && one_touch_mode);
  assign stop_now = key_cancel || ferr_trip || limit_stop;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ref_ff <= POS_RST;
    end else if (key_shift2) begin
      ref_ff <= enc_pos;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      disp_pos <= POS_RST;
      disp_diff <= 1'b0;
    end else if (key_shift3_held) begin
      disp_pos <= enc_pos - ref_ff;
      disp_diff <= 1'b1;
    end else if (rcl_view_ff || go_rcl_ff) begin
      disp_pos <= rd_pos;
      disp_diff <= 1'b0;
    end else begin
      disp_pos <= enc_pos;
      disp_diff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rcl_view_ff <= 1'b0;
    end else if (key_recall || key_up || key_down) begin
      rcl_view_ff <= 1'b1;
    end else if (key_go || key_store || key_cancel || key_digit) begin
      rcl_view_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cur_idx_ff <= IDX_RST;
    end else if (key_recall && recall_idx <= LAST_LOC) begin
      cur_idx_ff <= recall_idx;
    end else if (key_up && cur_idx_ff < LAST_LOC) begin
      cur_idx_ff <= cur_idx_ff + 7'h01;
    end else if (key_down && cur_idx_ff != IDX_RST) begin
      cur_idx_ff <= cur_idx_ff - 7'h01;
    end else if (wr_sq) begin
      cur_idx_ff <= nxt_seq_idx;
    end else if (seq_ff && move_done && !ferr_fault && !ferr_trip) begin
      cur_idx_ff <= (cur_idx_ff < LAST_LOC) ? cur_idx_ff + 7'h01 : cur_idx_ff;
    end
  end
  assign cur_idx = cur_idx_ff;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      node_id <= NODE_BCAST;
    end else if (node_cfg <= NODE_MAX) begin
      node_id <= node_cfg;
    end
  end
  assign node_match = (cmd_node == NODE_BCAST) || (cmd_node == node_id);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      limits <= '0;
    end else begin
      limits.fwd_en <= fwd_lim_on;
      limits.rev_en <= rev_lim_on;
      if (set_fwd_lim) begin
        limits.fwd_val <= enc_pos;
      end else if (lim_edit_fwd) begin
        limits.fwd_val <= entry_val;
      end
      if (set_rev_lim) begin
        limits.rev_val <= enc_pos;
      end else if (lim_edit_rev) begin
        limits.rev_val <= entry_val;
      end
    end
  end

  // pending recall go waits one cycle for the bank read
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      go_rcl_ff <= 1'b0;
    end else begin
      go_rcl_ff <= (key_go && !key_abs && !key_rel) || (key_digit && one_touch_mode);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      move_cmd <= '0;
      dir_fwd_ff <= 1'b1;
      seq_ff <= 1'b0;
    end else begin
      move_cmd.start <= 1'b0;
      if (stop_now) begin
        move_cmd.start <= 1'b0;
      end else if (key_go && (key_abs || key_rel)) begin
        move_cmd.target <= key_abs ? entry_val : enc_pos + entry_val;
        move_cmd.velocity <= base_vel;
        move_cmd.accel <= base_acc;
        move_cmd.start <= 1'b1;
        dir_fwd_ff <= key_abs ? ($signed(entry_val) >= $signed(enc_pos)) : !entry_val[POS_W-1];
        seq_ff <= 1'b0;
      end else if (go_rcl_ff) begin
        move_cmd.target <= rd_pos;
        move_cmd.velocity <= base_vel;
        move_cmd.accel <= base_acc;
        move_cmd.start <= 1'b1;
        dir_fwd_ff <= $signed(rd_pos) >= $signed(enc_pos);
        seq_ff <= seq_move;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      moving_ff <= 1'b0;
    end else if (stop_now || move_done) begin
      moving_ff <= 1'b0;
    end else if (move_cmd.start) begin
      moving_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      jog_ff <= 1'b0;
      free_ff <= 1'b0;
    end else begin
      jog_ff <= jog_active;
      if (ferr_trip || key_cancel) begin
        free_ff <= 1'b1;
      end else if (jog_ff && !jog_active && !hold_after_jog) begin
        free_ff <= 1'b1;
      end else if (jog_active || move_cmd.start || key_go) begin
        free_ff <= 1'b0;
      end
    end
  end
  assign drive_enable = !free_ff && !ferr_trip && !ferr_fault;
  assign loop_closed = drive_enable;
  assign estop = stop_now;

  always_comb begin
    acc_sel = SPSMG_ACC_NONE;
    jog_acc = base_acc;
    if (jog_active && jog_step_mode && !jog_shift_change) begin
      acc_sel = SPSMG_ACC_STEP;
      jog_acc = step_acc;
    end else if (jog_active || moving_ff) begin
      acc_sel = SPSMG_ACC_BASE;
    end
  end

  assign backlash_out = backlash;
endmodule
`default_nettype wire

// ===== spsmg_top_sva.sv
// port checker for the stage position store and motion guard
`timescale 1ns/1ps
`default_nettype none
module spsmg_top_sva import spsmg_pkg::*; (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [31:0] enc_pos,
  input wire logic jog_active,
  input wire logic hold_after_jog,
  input wire logic key_cancel,
  input wire logic key_shift2,
  input wire logic key_shift3_held,
  input wire logic key_abs,
  input wire logic key_rel,
  input wire logic key_go,
  input wire logic [31:0] entry_val,
  input wire logic [6:0] cmd_node,
  input wire logic [31:0] base_vel,
  input wire logic [31:0] base_acc,
  input wire logic [31:0] ferr_limit,
  input wire logic set_fwd_lim,
  input wire logic drive_enable,
  input wire logic loop_closed,
  input wire logic estop,
  input wire spsmg_move_t move_cmd,
  input wire logic [31:0] disp_pos,
  input wire logic disp_diff,
  input wire logic [6:0] node_id,
  input wire logic node_match,
  input wire spsmg_limits_t limits,
  input wire logic ferr_fault
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [31:0] ref_ff;
  logic free_go;
  // own copy of the reference, so a lost latch in the design shows
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ref_ff <= '0;
    end else if (key_shift2) begin
      ref_ff <= enc_pos;
    end
  end
  // only moves that no guard may refuse
  assign free_go = key_go && !key_cancel && !ferr_fault && ferr_limit == '0 &&
                   !limits.fwd_en && !limits.rev_en;
  a_abs_start: assert property (free_go && key_abs |=> move_cmd.start &&
    move_cmd.target == $past(entry_val) && move_cmd.velocity == $past(base_vel) &&
    move_cmd.accel == $past(base_acc)) else $error("abs start wrong");
  a_rel_start: assert property (free_go && key_rel |=> move_cmd.start &&
    move_cmd.target == $past(enc_pos) + $past(entry_val)) else $error("rel start wrong");
  a_cancel_stop: assert property (key_cancel |-> estop ##1 !move_cmd.start)
    else $error("cancel did not stop");
  a_release_jog: assert property ($fell(jog_active) && !hold_after_jog |->
    ##[0:1] !drive_enable) else $error("drive kept after jog");
  a_hold_jog: assert property ($fell(jog_active) && hold_after_jog && !key_cancel &&
    !ferr_fault |-> ##[0:1] loop_closed && drive_enable) else $error("hold lost after jog");
  a_diff_show: assert property (key_shift3_held && !key_shift2 |=> disp_diff &&
    disp_pos == $past(enc_pos) - $past(ref_ff)) else $error("difference wrong");
  a_node_match: assert property (node_id <= NODE_MAX &&
    node_match == (cmd_node == NODE_BCAST || cmd_node == node_id)) else $error("node match");
  a_fwd_capture: assert property (set_fwd_lim |=> limits.fwd_val == $past(enc_pos))
    else $error("fwd limit capture");
  a_fault_sticky: assert property (ferr_fault && !key_cancel && !key_go |=> ferr_fault)
    else $error("fault not sticky");
  a_fault_drive: assert property (ferr_fault |-> !drive_enable)
    else $error("drive on in fault");
  c_abs: cover property (free_go && key_abs);
  c_diff: cover property (key_shift3_held ##1 disp_diff);
  c_fault: cover property ($rose(ferr_fault));
endmodule
`default_nettype wire

// ===== test_stage_position_store_and_motion_guard.sv
// self-checking bench for the stage position store and motion guard
`timescale 1ns/1ps
`default_nettype none
module test_stage_position_store_and_motion_guard import spsmg_pkg::*;;
  logic clk_sys, resetn, jog_active, jog_step_mode, jog_dir_fwd, jog_shift_change;
  logic hold_after_jog, seq_store_mode, one_touch_mode, key_cancel, key_shift, key_shift2;
  logic key_shift3_held, key_store, store_insert, key_recall, key_up, key_down, key_digit;
  logic key_abs, key_rel, key_go, seq_move, set_fwd_lim, set_rev_lim, fwd_lim_on, rev_lim_on;
  logic lim_edit_fwd, lim_edit_rev, stall, move_done, drive_enable, loop_closed, estop;
  logic disp_diff, store_occupied, node_match, ferr_fault;
  logic [3:0] digit_val;
  logic [6:0] store_idx, recall_idx, node_cfg, cmd_node, cur_idx, node_id;
  logic [31:0] enc_pos, inst_target, entry_val, base_vel, base_acc, step_acc, backlash;
  logic [31:0] ferr_limit, jog_acc, backlash_out, disp_pos, r;
  spsmg_move_t move_cmd;
  spsmg_acc_sel_t acc_sel;
  spsmg_limits_t limits;
  logic [31:0] bank [100];
  logic used [100];
  int mismatches, n_compared, cycles;
  spsmg_top uut (.*);
  spsmg_drive_model drv (.*);
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end
  function automatic logic [31:0] tgt(input logic a, input logic [31:0] v, input logic [31:0] p);
    return a ? v : p + v;
  endfunction
  function automatic logic node_ok(input logic [6:0] c, input logic [6:0] n);
    return c == 7'h00 || c == n;
  endfunction
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic tap(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // bounded waits: a refused start must not hang the run
  task automatic wait_start(input logic [31:0] exp);
    int k;
    k = 0;
    while (move_cmd.start !== 1'h1 && k < 4) begin
      cyc(1);
      k++;
    end
    chk(32'(move_cmd.start), 32'h1, "start");
    chk(move_cmd.target, exp, "target");
    k = 0;
    while (move_done !== 1'h1 && k < 12) begin
      cyc(1);
      k++;
    end
    cyc(1);
  endtask
  task automatic mv(input logic a, input logic [31:0] v);
    logic [31:0] e;
    e = tgt(a, v, enc_pos);
    key_abs = a;
    key_rel = !a;
    entry_val = v;
    tap(key_go);
    key_abs = 1'h0;
    key_rel = 1'h0;
    wait_start(e);
  endtask
  task automatic occ(input logic [6:0] i, input logic exp);
    store_idx = i;
    cyc(2);
    chk(32'(store_occupied), 32'(exp), "occupied");
  endtask
  task automatic store(input logic [6:0] i, input logic ins);
    occ(i, used[i]);
    store_insert = ins;
    tap(key_store);
    store_insert = 1'h0;
    for (int j = 99; j > i && ins; j--) begin
      bank[j] = bank[j - 1];
      used[j] = used[j - 1];
    end
    bank[i] = enc_pos;
    used[i] = 1'h1;
  endtask
  task automatic recall(input logic [6:0] i);
    recall_idx = i;
    tap(key_recall);
    cyc(2);
  endtask
  task automatic go_to(input logic [31:0] exp);
    tap(key_go);
    wait_start(exp);
  endtask
  initial begin
    {jog_active, jog_step_mode, jog_dir_fwd, jog_shift_change, seq_store_mode, one_touch_mode,
     key_cancel, key_shift, key_shift2, key_shift3_held, key_store, store_insert, key_recall,
     key_up, key_down, key_digit, key_abs, key_rel, key_go, seq_move, set_fwd_lim, set_rev_lim,
     fwd_lim_on, rev_lim_on, lim_edit_fwd, lim_edit_rev, stall, digit_val, store_idx,
     recall_idx, node_cfg, cmd_node, entry_val, ferr_limit, resetn} = '0;
    foreach (used[j]) used[j] = 1'h0;
    hold_after_jog = 1'h1;
    void'($urandom(49579));
    base_vel = $urandom;
    base_acc = $urandom;
    step_acc = $urandom;
    backlash = $urandom;
    cyc(6);
    resetn = 1'h1;
    for (int j = 0; j < 8; j++) begin
      mv(j[0], $urandom & 32'h0000ffff);
    end
    mv(1'h1, 32'h1000);
    tap(key_shift2);
    for (int j = 0; j < 2; j++) begin
      r = $urandom & 32'h0fff;
      mv(1'h1, 32'h1000 + r);
      key_shift3_held = 1'h1;
      cyc(2);
      chk(disp_pos, r, "difference");
      key_shift3_held = 1'h0;
    end
    mv(1'h1, 32'h100);
    store(7'h05, 1'h0);
    mv(1'h1, 32'h200);
    store(7'h06, 1'h0);
    mv(1'h1, 32'h300);
    store(7'h0b, 1'h0);
    mv(1'h1, 32'h400);
    store(7'h05, 1'h1);
    recall(7'h06);
    chk(disp_pos, bank[6], "recall show");
    go_to(bank[6]);
    tap(key_up);
    cyc(2);
    go_to(bank[7]);
    tap(key_down);
    cyc(2);
    go_to(bank[6]);
    one_touch_mode = 1'h1;
    for (int j = 0; j < 2; j++) begin
      key_shift = j[0];
      digit_val = j[0] ? 4'h2 : 4'h5;
      tap(key_digit);
      wait_start(bank[j[0] ? 12 : 5]);
    end
    one_touch_mode = 1'h0;
    key_shift = 1'h0;
    seq_store_mode = 1'h1;
    recall(7'h14);
    chk(32'(cur_idx), 32'h14, "seq index");
    for (int j = 0; j < 2; j++) begin
      mv(1'h1, 32'h500 + 32'h100 * j);
      tap(key_store);
    end
    cyc(1);
    chk(32'(cur_idx), 32'h16, "seq index");
    seq_store_mode = 1'h0;
    occ(7'h15, 1'h0);
    seq_store_mode = 1'h1;
    mv(1'h1, 32'h0);
    ferr_limit = 32'h100;
    stall = 1'h1;
    seq_move = 1'h1;
    recall(7'h15);
    go_to(32'h500);
    chk(32'(ferr_fault), 32'h1, "fault");
    chk(32'(drive_enable), 32'h0, "drive off");
    chk(32'(cur_idx), 32'h15, "seq index");
    tap(key_cancel);
    cyc(1);
    chk(32'(ferr_fault), 32'h0, "fault clear");
    {stall, ferr_limit} = '0;
    go_to(32'h500);
    chk(32'(cur_idx), 32'h16, "seq advance");
    seq_move = 1'h0;
    {fwd_lim_on, rev_lim_on} = 2'h3;
    tap(set_fwd_lim);
    tap(set_rev_lim);
    cyc(1);
    chk(limits.rev_val, enc_pos, "rev limit");
    chk(32'({limits.fwd_en, limits.rev_en}), 32'h3, "limit on");
    r = enc_pos;
    mv(1'h1, r + 32'h100);
    chk(enc_pos, r, "limit stop");
    entry_val = $urandom;
    tap(lim_edit_fwd);
    tap(lim_edit_rev);
    {fwd_lim_on, rev_lim_on} = 2'h0;
    cyc(2);
    chk(limits.fwd_val, entry_val, "fwd edit");
    chk(limits.rev_val, entry_val, "rev edit");
    chk(32'({limits.fwd_en, limits.rev_en}), 32'h0, "limit off");
    for (int j = 0; j < 6; j++) begin
      node_cfg = 7'h01 + 7'($urandom % 99);
      cmd_node = j % 3 == 0 ? 7'h00 : (j % 3 == 1 ? node_cfg : 7'($urandom % 100));
      cyc(2);
      chk(32'(node_id), 32'(node_cfg), "node id");
      chk(32'(node_match), 32'(node_ok(cmd_node, node_cfg)), "node match");
    end
    r = 32'(node_id);
    node_cfg = 7'h70;
    cyc(2);
    chk(32'(node_id), r, "node range");
    chk(backlash_out, backlash, "backlash");
    jog_step_mode = 1'h1;
    jog_dir_fwd = 1'($urandom);
    jog_active = 1'h1;
    cyc(2);
    chk(32'(acc_sel), 32'(SPSMG_ACC_STEP), "step accel");
    chk(jog_acc, step_acc, "step accel");
    jog_shift_change = 1'h1;
    cyc(1);
    chk(32'(acc_sel), 32'(SPSMG_ACC_BASE), "shift accel");
    {jog_shift_change, jog_active} = 2'h0;
    cyc(2);
    chk(32'(loop_closed & drive_enable), 32'h1, "hold");
    tap(key_cancel);
    cyc(1);
    chk(32'(loop_closed), 32'h0, "cancel free");
    hold_after_jog = 1'h0;
    jog_active = 1'h1;
    cyc(2);
    jog_active = 1'h0;
    cyc(2);
    chk(32'(drive_enable), 32'h0, "release");
    final_report();
  end
endmodule
bind spsmg_top spsmg_top_sva chk (.*);
`default_nettype wire
